// ==== pkg/fps_map.svh ====
// constants for the flash program/erase/status controller
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH
// ******************************
// register offsets
// ******************************
`define FPS_REG_CTRL 4'h0
`define FPS_REG_ADDR 4'h1
`define FPS_REG_DATA 4'h2
`define FPS_REG_STAT 4'h3
`define FPS_REG_RDAT 4'h4
`define FPS_REG_TOUT 4'h5
// ******************************
// control fields and opcodes
// ******************************
`define FPS_CTRL_OP_LSB 0
`define FPS_CTRL_GO_BIT 4
`define FPS_CTRL_CS_TOG_BIT 5
`define FPS_CTRL_CE_WR_BIT 6
`define FPS_OP_READ 3'h0
`define FPS_OP_PROG 3'h1
`define FPS_OP_SECT_ERASE 3'h2
`define FPS_OP_CHIP_ERASE 3'h3
`define FPS_OP_PROTECT 3'h4
`define FPS_OP_UNPROTECT 3'h5
`define FPS_OP_RESET 3'h6
// ******************************
// status fields
// ******************************
`define FPS_ST_BUSY_BIT 0
`define FPS_ST_DONE_BIT 1
`define FPS_ST_TOUT_BIT 2
`define FPS_ST_FAIL_BIT 3
`define FPS_ST_SUSP_BIT 4
`define FPS_ST_VERIFY_BIT 5
// ******************************
// flash data and address bits and patterns
// ******************************
`define FPS_DQ_TOGGLE 6
`define FPS_DQ_SUSP 2
`define FPS_DQ_TOUT 5
`define FPS_ERASED 16'h00FF
`define FPS_PREPROG 8'h00
`define FPS_A6 6
`define FPS_A1 1
`define FPS_A0 0
// ******************************
// timing, in ns, us, ms, s and cycles
// ******************************
`define FPS_CLK_NS 8
`define FPS_BUS_NS 120
`define FPS_BUS_CYC ((`FPS_BUS_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_BUSY_NS 90
`define FPS_BUSY_CYC ((`FPS_BUSY_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_PROG_MAX_US 300
`define FPS_SERASE_MAX_S 5
`define FPS_CERASE_TYP_S 8
`define FPS_PROT_MAX_US 150
`define FPS_UNPR_MAX_MS 15
`define FPS_RST_NS 500
`define FPS_RST_CYC ((`FPS_RST_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`endif

// ==== pkg/fps_pkg.sv ====
// types for the flash program/erase/status controller
package fps_pkg;
  typedef enum logic [2:0] {
    FPS_READ, FPS_PROG, FPS_SERASE, FPS_CERASE, FPS_PROT, FPS_UNPROT, FPS_RST, FPS_RSV
  } fps_op_e;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic [19:0] addr;
  } fps_pins_s;
  typedef struct packed {
    logic [15:0] data;
    logic oe;
  } fps_dq_s;
endpackage

// ==== rtl/fps_ctrl.sv ====
// host controller driving flash program, erase, protect and status polling
// Functional notes
// - each status read is made by cycling both chip select and output enable, toggling bit 6.
// - a protect write holds address bits 6,1,0 at 0,1,0.
// - an unprotect write holds address bits 6,1,0 at 1,1,0.
// - a program command goes out as four bus write cycles.
`timescale 1ns/100ps
`include "fps_map.svh"
module fps_ctrl #(
  parameter int unsigned PROG_MAX_CYC = `FPS_PROG_MAX_US * 1000 / `FPS_CLK_NS,
  parameter longint unsigned SERASE_MAX_CYC = 64'(`FPS_SERASE_MAX_S) * 1000000000 / `FPS_CLK_NS,
  parameter longint unsigned CERASE_MAX_CYC = 64'(`FPS_CERASE_TYP_S) * 2000000000 / `FPS_CLK_NS,
  parameter int unsigned PROT_CYC = `FPS_PROT_MAX_US * 1000 / `FPS_CLK_NS,
  parameter int unsigned UNPR_CYC = `FPS_UNPR_MAX_MS * 1000000 / `FPS_CLK_NS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // flash pins
  output fps_pkg::fps_pins_s pins_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  input wire logic [15:0] dq_i,
  input wire logic ready_busy_n_i
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_PROT_WR, ST_PROT_WAIT, ST_POLL, ST_FINAL, ST_RSTP, ST_DONE
  } fps_state_e;
  fps_state_e state;
  logic [6:0] ctrl;
  logic [19:0] faddr;
  logic [15:0] fdata;
  logic [15:0] rdat;
  logic [15:0] prev;
  logic have_prev;
  logic st_done;
  logic st_tout;
  logic st_fail;
  logic st_susp;
  logic st_verify;
  logic [39:0] tmr;
  logic [39:0] limit;
  logic [2:0] step;
  logic cyc_start;
  logic cyc_write;
  logic [19:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  fps_pkg::fps_pins_s cyc_pins;
  fps_pkg::fps_dq_s cyc_dq;
  fps_pkg::fps_op_e op;
  logic go;
  logic [19:0] prot_addr;
  assign op = fps_pkg::fps_op_e'(ctrl[`FPS_CTRL_OP_LSB +: 3]);
  assign go = wr_i && addr_i == `FPS_REG_CTRL && wdata_i[`FPS_CTRL_GO_BIT];
  assign prot_addr = {faddr[19:7], op == fps_pkg::FPS_UNPROT, faddr[5:2], 2'b10};
  // ******************************
  // bus cycle engine
  // ******************************
  fps_cycle u_cycle (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .start_i(cyc_start),
    .write_i(cyc_write),
    .ce_ctl_i(ctrl[`FPS_CTRL_CE_WR_BIT]),
    .addr_i(cyc_addr),
    .wdata_i(cyc_wdata),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .dq_i(dq_i),
    .pins_o(cyc_pins),
    .dq_o(cyc_dq)
  );
  // ******************************
  // pin drive
  // ******************************
  always_comb
  begin
    pins_o = cyc_pins;
    pins_o.reset_n = (state != ST_RSTP);
    dq_o = cyc_dq.data;
    dq_oe_o = cyc_dq.oe;
  end
  // ******************************
  // command words per step
  // ******************************
  always_comb
  begin
    cyc_addr = 20'h00555;
    cyc_wdata = 16'h00AA;
    unique case (step)
      3'd1: begin cyc_addr = 20'h002AA; cyc_wdata = 16'h0055; end
      3'd2: cyc_wdata = (op == fps_pkg::FPS_PROG) ? 16'h00A0 : 16'h0080;
      3'd3: if (op == fps_pkg::FPS_PROG)
        begin
          cyc_addr = faddr;
          cyc_wdata = fdata;
        end
      3'd4: begin cyc_addr = 20'h002AA; cyc_wdata = 16'h0055; end
      3'd5: if (op == fps_pkg::FPS_SERASE)
        begin
          cyc_addr = faddr;
          cyc_wdata = 16'h0030;
        end
        else
          cyc_wdata = 16'h0010;
      default: ;
    endcase
    if (state == ST_PROT_WR)
    begin
      cyc_addr = prot_addr;
      cyc_wdata = 16'h0060;
    end
    else if (state == ST_POLL || state == ST_FINAL || op == fps_pkg::FPS_READ)
      cyc_addr = faddr;
  end
  assign cyc_write = (state == ST_CMD || state == ST_PROT_WR);
  assign cyc_start = (state == ST_CMD || state == ST_PROT_WR || state == ST_POLL
    || state == ST_FINAL) && !cyc_done;
  // ******************************
  // sequencer
  // ******************************
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_IDLE;
      step <= 3'h0;
      tmr <= 40'h0000000000;
      limit <= 40'h0000000000;
      have_prev <= 1'b0;
      prev <= 16'h0000;
      rdat <= 16'h0000;
      st_done <= 1'b0;
      st_tout <= 1'b0;
      st_fail <= 1'b0;
      st_susp <= 1'b0;
      st_verify <= 1'b0;
    end
    else
    begin
      if (state != ST_IDLE && state != ST_DONE)
        tmr <= tmr + 40'h0000000001;
      unique case (state)
        ST_IDLE, ST_DONE:
          if (go)
          begin
            tmr <= 40'h0000000000;
            step <= 3'h0;
            have_prev <= 1'b0;
            {st_done, st_tout, st_fail, st_susp, st_verify} <= 5'h00;
            unique case (fps_pkg::fps_op_e'(wdata_i[`FPS_CTRL_OP_LSB +: 3]))
              fps_pkg::FPS_READ: state <= ST_FINAL;
              fps_pkg::FPS_RST: state <= ST_RSTP;
              fps_pkg::FPS_PROT:
              begin
                limit <= 40'(PROT_CYC);
                state <= ST_PROT_WR;
              end
              fps_pkg::FPS_UNPROT:
              begin
                limit <= 40'(UNPR_CYC);
                state <= ST_PROT_WR;
              end
              fps_pkg::FPS_PROG:
              begin
                limit <= 40'(PROG_MAX_CYC);
                state <= ST_CMD;
              end
              fps_pkg::FPS_SERASE:
              begin
                limit <= SERASE_MAX_CYC[39:0];
                state <= ST_CMD;
              end
              default:
              begin
                limit <= CERASE_MAX_CYC[39:0];
                state <= ST_CMD;
              end
            endcase
          end
        ST_CMD:
          if (cyc_done)
          begin
            step <= step + 3'h1;
            if ((op == fps_pkg::FPS_PROG && step == 3'h3) || step == 3'h5)
            begin
              tmr <= 40'h0000000000;
              state <= ST_POLL;
            end
          end
        ST_PROT_WR:
          if (cyc_done)
          begin
            tmr <= 40'h0000000000;
            state <= ST_PROT_WAIT;
          end
        ST_PROT_WAIT:
          if (tmr >= limit)
            state <= ST_FINAL;
        // successive reads with own chip select
        ST_POLL:
          if (cyc_done)
          begin
            prev <= cyc_rdata;
            have_prev <= 1'b1;
            if (have_prev && cyc_rdata[`FPS_DQ_TOGGLE] == prev[`FPS_DQ_TOGGLE]
              && ready_busy_n_i)
              state <= ST_FINAL;
            else if (have_prev && cyc_rdata[`FPS_DQ_SUSP] != prev[`FPS_DQ_SUSP]
              && !ready_busy_n_i)
              st_susp <= 1'b1;
            if (cyc_rdata[`FPS_DQ_TOUT] && have_prev && !ready_busy_n_i
              && cyc_rdata[`FPS_DQ_TOGGLE] != prev[`FPS_DQ_TOGGLE])
            begin
              st_fail <= 1'b1;
              state <= ST_FINAL;
            end
            if (tmr >= limit)
            begin
              st_tout <= 1'b1;
              state <= ST_FINAL;
            end
          end
        ST_FINAL:
          if (cyc_done)
          begin
            rdat <= cyc_rdata;
            if (op == fps_pkg::FPS_SERASE || op == fps_pkg::FPS_CERASE)
              st_verify <= {8'h00, cyc_rdata[7:0]} == `FPS_ERASED;
            else if (op == fps_pkg::FPS_PROG)
              st_verify <= cyc_rdata == fdata;
            else
              st_verify <= 1'b1;
            st_done <= 1'b1;
            state <= ST_DONE;
          end
        ST_RSTP:
          if (tmr >= 40'(`FPS_RST_CYC))
          begin
            st_done <= 1'b1;
            state <= ST_DONE;
          end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ******************************
  // register file
  // ******************************
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl <= 7'h00;
      faddr <= 20'h00000;
      fdata <= 16'h0000;
      rdata_o <= 32'h00000000;
    end
    else
    begin
      if (wr_i && (state == ST_IDLE || state == ST_DONE))
      begin
        if (addr_i == `FPS_REG_CTRL)
          ctrl <= wdata_i[6:0];
        if (addr_i == `FPS_REG_ADDR)
          faddr <= wdata_i[19:0];
        if (addr_i == `FPS_REG_DATA)
          fdata <= wdata_i[15:0];
      end
      rdata_o <= 32'h00000000;
      if (rd_i)
        unique case (addr_i)
          `FPS_REG_CTRL: rdata_o <= {25'h0000000, ctrl};
          `FPS_REG_ADDR: rdata_o <= {12'h000, faddr};
          `FPS_REG_DATA: rdata_o <= {16'h0000, fdata};
          `FPS_REG_STAT: rdata_o <= {25'h0000000, !ready_busy_n_i, st_verify, st_susp,
            st_fail, st_tout, st_done, state != ST_IDLE && state != ST_DONE};
          `FPS_REG_RDAT: rdata_o <= {16'h0000, rdat};
          `FPS_REG_TOUT: rdata_o <= tmr[31:0];
          default: rdata_o <= 32'h00000000;
        endcase
    end
  end
endmodule

// ==== rtl/fps_cycle.sv ====
// one asynchronous bus cycle on the flash pins
`timescale 1ns/100ps
`include "fps_map.svh"
module fps_cycle (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // request
  input wire logic start_i,
  input wire logic write_i,
  input wire logic ce_ctl_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // flash side
  input wire logic [15:0] dq_i,
  output fps_pkg::fps_pins_s pins_o,
  output fps_pkg::fps_dq_s dq_o
);
  logic [4:0] cnt;
  logic busy;
  logic wr;
  logic ce_ctl;
  // ******************************
  // strobe timing
  // ******************************
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt <= 5'h00;
      busy <= 1'b0;
      wr <= 1'b0;
      ce_ctl <= 1'b0;
      pins_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, addr: 20'h00000};
      dq_o <= '{data: 16'h0000, oe: 1'b0};
      rdata_o <= 16'h0000;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy)
      begin
        busy <= 1'b1;
        cnt <= 5'h00;
        wr <= write_i;
        ce_ctl <= ce_ctl_i;
        pins_o.addr <= addr_i;
        dq_o <= '{data: wdata_i, oe: write_i};
        if (write_i && ce_ctl_i)
          pins_o.we_n <= 1'b0;
        else
          pins_o.ce_n <= 1'b0;
      end
      else if (busy)
      begin
        cnt <= cnt + 5'h01;
        if (cnt == 5'h01)
        begin
          if (!wr)
            pins_o.oe_n <= 1'b0;
          else if (ce_ctl)
            pins_o.ce_n <= 1'b0;
          else
            pins_o.we_n <= 1'b0;
        end
        if (cnt == 5'(`FPS_BUS_CYC))
        begin
          if (wr && ce_ctl)
            pins_o.ce_n <= 1'b1;
          else if (wr)
            pins_o.we_n <= 1'b1;
          else
          begin
            rdata_o <= dq_i;
            pins_o.oe_n <= 1'b1;
          end
        end
        if (cnt == 5'(`FPS_BUS_CYC + 1))
        begin
          pins_o.ce_n <= 1'b1;
          pins_o.we_n <= 1'b1;
        end
        if (cnt == 5'(`FPS_BUS_CYC + 2))
        begin
          busy <= 1'b0;
          dq_o.oe <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== verification/fps_ctrl_properties.sv ====
// checker on the flash controller ports
`timescale 1ns/100ps
module fps_ctrl_properties (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // flash pins
  input wire fps_pkg::fps_pins_s pins_o,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic [15:0] dq_i,
  input wire logic ready_busy_n_i
);
  // ******************************
  // helper state
  // ******************************
  logic wstb, rstb, wstb_q, rstb_q, seen_rd;
  logic [2:0] last_op;
  logic [3:0] wcnt;
  assign wstb = pins_o.ce_n | pins_o.we_n;
  assign rstb = pins_o.ce_n | pins_o.oe_n;
  function automatic logic [3:0] n_wr(input logic [2:0] op);
    case (op)
      3'h1: n_wr = 4'h4;
      3'h2, 3'h3: n_wr = 4'h6;
      default: n_wr = 4'h1;
    endcase
  endfunction
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wstb_q <= 1'b1;
      rstb_q <= 1'b1;
      seen_rd <= 1'b0;
      last_op <= 3'h0;
      wcnt <= 4'h0;
    end
    else
    begin
      wstb_q <= wstb;
      rstb_q <= rstb;
      if (wr_i && addr_i == 4'h0 && wdata_i[4])
      begin
        last_op <= wdata_i[2:0];
        wcnt <= 4'h0;
        seen_rd <= 1'b0;
      end
      else
      begin
        if (wstb && !wstb_q)
          wcnt <= wcnt + 4'h1;
        if (!rstb && rstb_q)
          seen_rd <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read slot");
  AST_RD_STROBE: assert property ($fell(rstb) |-> ##[8:30] $rose(rstb))
    else $error("read strobe not cycled per status read");
  AST_WR_STROBE: assert property ($fell(wstb) |-> (!wstb) [*8] ##[1:30] wstb)
    else $error("write strobe width wrong");
  AST_NO_CONTENTION: assert property (!rstb |-> !dq_oe_o)
    else $error("controller drives data during read");
  AST_WR_DRIVE: assert property (!wstb |-> dq_oe_o)
    else $error("data not driven during write");
  AST_ADDR_HOLD: assert property (!wstb && !$past(wstb) |-> $stable(pins_o.addr))
    else $error("address moved inside write strobe");
  AST_PROT_SEL: assert property (!wstb && dq_oe_o && dq_o[7:0] == 8'h60 |->
    pins_o.addr[1:0] == 2'b10 && pins_o.addr[6] == (last_op == 3'h5))
    else $error("protect select address bits wrong");
  AST_CMD_CNT: assert property ($fell(rstb) && !seen_rd && last_op inside {[3'h1:3'h5]} |->
    wcnt == n_wr(last_op))
    else $error("command write count wrong");
  AST_RST_PIN: assert property (!pins_o.reset_n |-> last_op == 3'h6)
    else $error("reset pin low outside reset op");
endmodule
bind fps_ctrl fps_ctrl_properties u_fps_ctrl_properties (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pins_o(pins_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i),
  .ready_busy_n_i(ready_busy_n_i));

// ==== verification/fps_ctrl_test.sv ====
// self-checking bench for the flash controller
`timescale 1ns/100ps
module fps_ctrl_test;
  // ******************************
  // bench signals and instances
  // ******************************
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rdata, v;
  fps_pkg::fps_pins_s pins;
  logic [15:0] cdq, mdq, dq;
  logic coe, moe, rbn;
  int fails = 0;
  int compares = 0;
  always #4 mclk_i = ~mclk_i;
  assign dq = coe ? cdq : mdq;
  fps_ctrl #(.PROG_MAX_CYC(200), .SERASE_MAX_CYC(200), .CERASE_MAX_CYC(200), .PROT_CYC(200),
    .UNPR_CYC(200)) u_fps_ctrl (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pins_o(pins), .dq_o(cdq),
    .dq_oe_o(coe), .dq_i(dq), .ready_busy_n_i(rbn));
  fps_flash_model u_fps_flash_model (.pins_i(pins), .dq_i(dq), .slow_i(slow), .dq_o(mdq),
    .dq_oe_o(moe), .ready_busy_n_o(rbn));
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic poll;
    v = 32'h0;
    for (int i = 0; i < 400 && (v[1] !== 1'b1 || v[0] !== 1'b0); i++)
      rd_reg(4'h3, v);
  endtask
  task automatic run(input logic [31:0] ctl);
    wr_reg(4'h0, ctl | 32'h10);
    poll();
  endtask
  task automatic readback(input logic [31:0] a, input logic [31:0] exp);
    wr_reg(4'h1, a);
    run(32'h0);
    rd_reg(4'h4, v);
    chk(v, exp);
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    fails++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd_reg(4'h3, v);
    chk(v, 32'h0);
    rd_reg(4'hF, v);
    chk(v, 32'h0);
    // program, address write ignored while busy
    wr_reg(4'h1, 32'h12);
    wr_reg(4'h2, 32'h5A);
    wr_reg(4'h0, 32'h11);
    wr_reg(4'h1, 32'h40);
    poll();
    chk(v & 32'h3F, 32'h22);
    rd_reg(4'h1, v);
    chk(v, 32'h12);
    readback(32'h12, 32'h5A);
    // chip-select controlled program
    wr_reg(4'h1, 32'h13);
    wr_reg(4'h2, 32'h33);
    run(32'h41);
    readback(32'h13, 32'h33);
    wr_reg(4'h1, 32'h25);
    wr_reg(4'h2, 32'h0F);
    run(32'h1);
    // sector erase keeps other sectors, chip erase clears them all
    wr_reg(4'h1, 32'h12);
    run(32'h2);
    chk(v & 32'h3F, 32'h22);
    readback(32'h13, 32'hFF);
    readback(32'h25, 32'h0F);
    run(32'h3);
    chk(v & 32'h3F, 32'h22);
    readback(32'h25, 32'hFF);
    // protect and unprotect
    for (int op = 4; op < 6; op++)
    begin
      run(32'(op));
      chk(v & 32'hF, 32'h2);
    end
    // overrunning program reports failure
    slow <= 1'b1;
    wr_reg(4'h1, 32'h30);
    wr_reg(4'h2, 32'h00);
    run(32'h1);
    chk(v & 32'h8, 32'h8);
    slow <= 1'b0;
    run(32'h6);
    chk(v & 32'h3, 32'h2);
    readback(32'h30, 32'hFF);
    conclude();
  end
endmodule

// ==== verification/fps_flash_model.sv ====
// behavioural model of the parallel flash
`timescale 1ns/100ps
module fps_flash_model #(
  parameter int PROG_NS = 400,
  parameter int PMAX_NS = 600,
  parameter int ERASE_NS = 1000,
  parameter int PROT_NS = 600,
  parameter int UNPR_NS = 1200
) (
  // flash pins
  input wire fps_pkg::fps_pins_s pins_i,
  input wire logic [15:0] dq_i,
  input wire logic slow_i,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic ready_busy_n_o
);
  // ******************************
  // array and command state
  // ******************************
  logic [15:0] mem [256];
  logic [19:0] la = 20'h0;
  logic [15:0] ld = 16'h0;
  logic [15:0] lastq = 16'h0;
  logic [15:0] drv;
  logic [2:0] step = 3'h0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic tout = 1'b0;
  wire wstb = pins_i.ce_n | pins_i.we_n;
  wire rstb = pins_i.ce_n | pins_i.oe_n;
  initial
    foreach (mem[i]) mem[i] = 16'h00FF;
  assign ready_busy_n_o = ~busy;
  // status while busy, bit 2 held
  assign drv = busy ? {9'h000, tog, tout, 5'h00} : mem[pins_i.addr[7:0]];
  assign dq_oe_o = ~rstb;
  assign dq_o = rstb ? lastq : drv;
  always @(posedge rstb) lastq = ~drv;
  always @(negedge rstb) if (busy) tog = ~tog;
  always @(negedge wstb) la = pins_i.addr;
  always @(negedge pins_i.reset_n) step = 3'h0;
  always @(posedge wstb)
  begin
    ld = dq_i;
    if (!busy)
      case (step)
        3'h0:
        begin
          step = (ld[7:0] === 8'hAA) ? 3'h1 : 3'h0;
          if (ld[7:0] === 8'h60)
          begin
            busy = 1'b1;
            #(la[6] ? UNPR_NS : PROT_NS);
            busy = 1'b0;
          end
        end
        3'h1: step = (ld[7:0] === 8'h55) ? 3'h2 : 3'h0;
        3'h2: step = (ld[7:0] === 8'hA0) ? 3'h3 : (ld[7:0] === 8'h80) ? 3'h4 : 3'h0;
        3'h3:
        begin
          step = 3'h0;
          busy = 1'b1;
          #(slow_i ? PMAX_NS : PROG_NS);
          if (slow_i)
          begin
            tout = 1'b1;
            #(PMAX_NS);
          end
          else
            mem[la[7:0]] = mem[la[7:0]] & ld;
          busy = 1'b0;
          tout = 1'b0;
        end
        3'h4: step = (ld[7:0] === 8'hAA) ? 3'h5 : 3'h0;
        3'h5: step = (ld[7:0] === 8'h55) ? 3'h6 : 3'h0;
        default:
        begin
          step = 3'h0;
          if (ld[7:0] === 8'h30 || ld[7:0] === 8'h10)
          begin
            busy = 1'b1;
            foreach (mem[i]) if (!ld[5] || i[7:4] == la[7:4]) mem[i] = 16'h0000;
            #(ERASE_NS);
            foreach (mem[i]) if (!ld[5] || i[7:4] == la[7:4]) mem[i] = 16'h00FF;
            busy = 1'b0;
          end
        end
      endcase
  end
endmodule
